// File: tiered_irq_params.svh
// constants for the tiered interrupt aggregation block
// assumes a 32-bit axi4-lite slave with word-aligned registers
`ifndef TIERED_IRQ_PARAMS_SVH
`define TIERED_IRQ_PARAMS_SVH
`define OFS_SUMMARY   12'h000
`define OFS_CTRL      12'h004
`define OFS_MSI       12'h008
`define OFS_PORTS     12'h00C
`define OFS_STATUS_B  12'h100
`define OFS_MASK_B    12'h180
`define CTRL_IE_BIT   0
`define CTRL_FB_BIT   1
`define MSI_ON_BIT    0
`define MSI_MME_LSB   4
`define MSI_MMC_LSB   1
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`define MAX_MSG       16
`endif

// File: tiered_irq_pkg.sv
// types shared by the interrupt aggregation block
// assumes the params header is compiled alongside
package tiered_irq_pkg;
	typedef struct packed {
		logic       valid;
		logic [4:0] vector;
	} msi_req_s;
	typedef enum logic [2:0] {
		MODE_WIRE   = 3'b001,
		MODE_SINGLE = 3'b010,
		MODE_MULTI  = 3'b100
	} irq_mode_e;
endpackage : tiered_irq_pkg

// File: port_event_slice.sv
// one port: sticky event status, enable mask, virtual wire, send trigger
// assumes status clears come from the bus as write-one-to-clear
`timescale 1ns/1ps
module port_event_slice #(
	parameter int W = 32
) (
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] event_in,
	input  wire logic [W-1:0] clr_mask,
	input  wire logic         mask_we,
	input  wire logic [W-1:0] mask_wdata,
	output logic      [W-1:0] status,
	output logic      [W-1:0] mask,
	output logic              vwire,
	output logic              trigger
);
	typedef struct packed {
		logic [W-1:0] st;
		logic [W-1:0] en;
	} slice_s;
	slice_s q, d;
	logic [W-1:0] new_st;
	logic [W-1:0] new_en;
	// set wins over a coincident clear
	always_comb begin
		d = q;
		new_st = (q.st & ~clr_mask) | event_in;
		new_en = mask_we ? mask_wdata : q.en;
		d.st = new_st;
		d.en = new_en;
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign status = q.st;
	assign mask   = q.en;
	assign vwire  = |(q.st & q.en);
	// new enabled bit, partial clear leaving enabled bits, or enable rising on set status
	assign trigger = (|(d.st & ~q.st & d.en))
		| ((|(q.st & ~d.st)) & (|(d.st & d.en)))
		| (|(d.en & ~q.en & d.st));
endmodule : port_event_slice

// File: tiered_msi_interrupt_logic.sv
// top of the interrupt aggregation: axi4-lite registers, port slices, msi issue
// assumes events are same-clock pulses and msi_ack is from the bus master logic
// assumes software keeps one write and one read outstanding at most
// assumes the grant field is written only while the block is quiet
// the fallback choice is fixed at build time, not by software
`timescale 1ns/1ps
`include "tiered_irq_params.svh"
module tiered_msi_interrupt_logic
	import tiered_irq_pkg::*;
#(
	parameter int         NPORTS    = 6,
	parameter int         EW        = 32,
	parameter logic [31:0] PORTS_MAP = 32'h0000003F,
	parameter logic       FALLBACK  = 1'b0
) (
	input  wire logic                ref_clk,
	input  wire logic                rst,
	// per-port event pulses, one 32-bit word a port
	input  wire logic [NPORTS*EW-1:0] port_events,
	// host side: wire line and message requests with back-pressure
	output logic                     irq_wire_n,
	output msi_req_s                 msi_req,
	input  wire logic                msi_ack,
	// axi4-lite write side: address, data and response channels
	input  wire logic [11:0]         s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	// axi4-lite read side: address and data channels
	input  wire logic [11:0]         s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready
);

	// highest summary bit in use fixes the capable count
	// worked out at elaboration, so the field costs no logic
	// limited to 32 ports, the width of the summary word
	function automatic logic [2:0] log2_cover(input int n);
		logic [2:0] r;
		r = 3'h0;
		for (int i = 0; i < 6; i++) begin
			if ((1 << i) < n) begin
				r = 3'(i + 1);
			end
		end
		return r;
	endfunction : log2_cover
	localparam logic [2:0] CAP_CNT = log2_cover(NPORTS);


	// whole state of the top in one record
	typedef struct packed {
		// first tier and global controls
		logic [31:0] summary;
		logic        gie;
		logic        msi_on;
		logic [2:0]  granted;
		// message bookkeeping: previous summary, pending sends, request
		logic [31:0] last_summary;
		logic        pend;
		logic [4:0]  pend_vec;
		logic [`MAX_MSG-1:0] pend_multi;
		logic        req_v;
		logic [4:0]  req_vec;
		// write halves held until both are in
		logic        aw_have;
		logic [11:0] aw_addr;
		logic        w_have;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		// bus answers
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		// registered so the pin never glitches
		logic        wire_n;
	} top_s;
	top_s q, d;

	logic [NPORTS-1:0]    vwire;
	logic [NPORTS-1:0]    ptrig;
	logic [EW-1:0]        pst   [NPORTS];
	logic [EW-1:0]        pen   [NPORTS];
	logic [NPORTS-1:0]    st_clr_sel;
	logic [NPORTS-1:0]    en_we_sel;
	logic                 wr_go;
	logic [31:0]          wmask;


	// both halves of a write must be held before it retires
	// a pending response stalls the next write instead of losing it
	assign wr_go = q.aw_have && q.w_have && !q.bvalid;
	always_comb begin
		wmask = '0;
		for (int b = 0; b < 4; b++) begin
			if (q.w_strb[b]) begin
				wmask[b*8 +: 8] = 8'hFF;
			end
		end
	end


	// port slices: status and enable state per port
	// byte strobes merge into the mask so partial writes keep other bytes
	for (genvar p = 0; p < NPORTS; p++) begin : g_port
		assign st_clr_sel[p] = wr_go && (q.aw_addr == 12'(`OFS_STATUS_B + 4*p));
		assign en_we_sel[p]  = wr_go && (q.aw_addr == 12'(`OFS_MASK_B + 4*p));
		port_event_slice #(.W(EW)) u_slice (
			.ref_clk    (ref_clk),
			.rst        (rst),
			.event_in   (port_events[p*EW +: EW]),
			.clr_mask   (st_clr_sel[p] ? (q.w_data & wmask) : '0),
			.mask_we    (en_we_sel[p]),
			.mask_wdata ((q.w_data & wmask) | (pen[p] & ~wmask)),
			.status     (pst[p]),
			.mask       (pen[p]),
			.vwire      (vwire[p]),
			.trigger    (ptrig[p])
		);
	end


	// signalling mode from the msi controls and the grant
	// a short grant shares the last message unless built to fall back
	// grant zero with msi on behaves as a single message
	irq_mode_e mode;
	logic      short_grant;
	logic [4:0] grant_n;
	always_comb begin
		grant_n = 5'(1 << q.granted);
		short_grant = (q.granted < CAP_CNT);
		if (!q.msi_on || q.granted == 3'h0) begin
			mode = q.msi_on ? MODE_SINGLE : MODE_WIRE;
		end else if (short_grant && FALLBACK) begin
			mode = MODE_SINGLE;
		end else begin
			mode = MODE_MULTI;
		end
	end


	logic [31:0] rd_word;
	// read mux, decoded straight from the address on the bus
	// a status or mask word is picked by its port's offset
	always_comb begin
		rd_word = 32'h00000000;
		case (s_axi_araddr)
			`OFS_SUMMARY: rd_word = q.summary;
			`OFS_CTRL:    rd_word = {30'h0, FALLBACK & short_grant & q.msi_on,
				q.gie};
			`OFS_MSI:     rd_word = {25'h0, q.granted, CAP_CNT, q.msi_on};
			`OFS_PORTS:   rd_word = PORTS_MAP;
			default: begin
				for (int p = 0; p < NPORTS; p++) begin
					if (s_axi_araddr == 12'(`OFS_STATUS_B + 4*p)) begin
						rd_word = 32'(pst[p]);
					end
					if (s_axi_araddr == 12'(`OFS_MASK_B + 4*p)) begin
						rd_word = 32'(pen[p]);
					end
				end
			end
		endcase
	end


	// main next-state logic: decode, summary, messages, bus channels
	// unmapped offsets answer with an error rather than hang the bus, except unaligned writes up to OFS_PORTS, which answer okay
	logic        rd_hit;
	logic        wr_hit;
	logic [31:0] sum_next;
	logic        single_ev;
	logic [`MAX_MSG-1:0] multi_ev;
	logic [4:0]  vec;
	always_comb begin
		rd_hit = (s_axi_araddr <= `OFS_PORTS) && (s_axi_araddr[1:0] == 2'h0);
		wr_hit = (q.aw_addr <= `OFS_PORTS);
		for (int p = 0; p < NPORTS; p++) begin
			if (s_axi_araddr == 12'(`OFS_STATUS_B + 4*p)) rd_hit = 1'b1;
			if (s_axi_araddr == 12'(`OFS_MASK_B + 4*p)) rd_hit = 1'b1;
			if (q.aw_addr == 12'(`OFS_STATUS_B + 4*p)) wr_hit = 1'b1;
			if (q.aw_addr == 12'(`OFS_MASK_B + 4*p)) wr_hit = 1'b1;
		end
		d = q;
		vec = 5'h00;
		// summary: w1c, but live wire level re-sets the bit
		// set wins, so a clear racing a live wire never loses the port
		sum_next = q.summary;
		if (wr_go && q.aw_addr == `OFS_SUMMARY) begin
			sum_next = q.summary & ~(q.w_data & wmask);
		end
		sum_next = sum_next | 32'(vwire);
		d.summary = sum_next;
		d.last_summary = q.summary;
		if (wr_go && q.aw_addr == `OFS_CTRL && q.w_strb[0]) begin
			d.gie = q.w_data[`CTRL_IE_BIT];
		end
		if (wr_go && q.aw_addr == `OFS_MSI && q.w_strb[0]) begin
			d.msi_on  = q.w_data[`MSI_ON_BIT];
			d.granted = (q.w_data[`MSI_MME_LSB +: 3] > CAP_CNT) ? CAP_CNT
				: q.w_data[`MSI_MME_LSB +: 3];
		end
		// any change that leaves a bit set sends in single mode
		// compared one cycle late, so the send trails the summary by two
		single_ev = (q.summary != q.last_summary) && (q.summary != 32'h0);
		// map ports to messages, overflow to the top granted one
		multi_ev = '0;
		for (int p = 0; p < NPORTS; p++) begin
			vec = (p < 32'(grant_n)) ? 5'(p) : 5'(grant_n - 5'h1);
			if (ptrig[p] && vec < 5'(`MAX_MSG)) begin
				multi_ev[vec[3:0]] = 1'b1;
			end
		end
		// events park in pending while a request is outstanding
		// many events for one message in that time merge into one further send
		if (mode == MODE_SINGLE && single_ev) d.pend = 1'b1;
		if (mode == MODE_MULTI) d.pend_multi = q.pend_multi | multi_ev;
		if (!q.gie || !q.msi_on) begin
			d.pend = 1'b0;
			d.pend_multi = '0;
		end
		// issue one request a cycle at most, lowest message first
		// back-pressure holds the pending bits, it never drops them
		d.req_v = 1'b0;
		if (q.gie && !q.req_v && !msi_ack) begin
			if (q.pend) begin
				d.req_v = 1'b1;
				d.req_vec = 5'h0;
				d.pend = 1'b0;
			end else if (|q.pend_multi) begin
				for (int m = `MAX_MSG-1; m >= 0; m--) begin
					if (q.pend_multi[m]) d.req_vec = 5'(m);
				end
				d.req_v = 1'b1;
				d.pend_multi[d.req_vec[3:0]] = multi_ev[d.req_vec[3:0]];
			end
		end
		// wire is a level: follows the summary one cycle later
		d.wire_n = !(mode == MODE_WIRE && q.gie && (|q.summary));
		// axi write capture, either order
		if (s_axi_awvalid && s_axi_awready) begin
			d.aw_have = 1'b1;
			d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			d.w_have = 1'b1;
			d.w_data = s_axi_wdata;
			d.w_strb = s_axi_wstrb;
		end
		if (wr_go) begin
			d.aw_have = 1'b0;
			d.w_have = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
		end
		if (q.bvalid && s_axi_bready) d.bvalid = 1'b0;

		// axi read: one cycle to data
		// data are frozen in the state until the master takes them
		if (s_axi_arvalid && s_axi_arready) begin
			d.rvalid = 1'b1;
			d.rdata = rd_hit ? rd_word : 32'h0;
			d.rresp = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
	end

	// state register; the wire line idles high out of reset
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			q <= '0;
			q.wire_n <= 1'b1;
		end else begin
			q <= d;
		end
	end


	// ready is low only while a channel's item is held
	assign s_axi_awready = !q.aw_have;
	assign s_axi_wready  = !q.w_have;
	assign s_axi_bvalid  = q.bvalid;
	assign s_axi_bresp   = q.bresp;
	assign s_axi_arready = !q.rvalid;
	assign s_axi_rvalid  = q.rvalid;
	assign s_axi_rdata   = q.rdata;
	assign s_axi_rresp   = q.rresp;
	// host side outputs straight from flip-flops
	assign irq_wire_n    = q.wire_n;
	assign msi_req.valid  = q.req_v;
	assign msi_req.vector = q.req_vec;
endmodule : tiered_msi_interrupt_logic

// File: tiered_msi_interrupt_logic_assertions.sv
// port checker for the tiered interrupt block: bus answers and message pulses
// assumes one ref_clk domain with a synchronous active-high rst
`timescale 1ns/1ps
module irq_port_checker
	import tiered_irq_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        irq_wire_n,
	input wire msi_req_s    msi_req,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	// message requests: one-cycle pulses; a stuck pending flag repeats them rather than stretching one
	a_msg_one_cycle: assert property (msi_req.valid |=> !msi_req.valid)
		else $error("message request longer than one cycle");
	a_msg_vector_range: assert property (msi_req.valid |-> msi_req.vector < 5'h10)
		else $error("message number beyond sixteen");
	a_release_quiet: assert property ($fell(rst) |-> irq_wire_n && !msi_req.valid)
		else $error("wire or message active out of reset");
	// bus answers, one read and one write at a time
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	a_read_no_overlap: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while answering");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |-> ##[1:3] s_axi_bvalid)
		else $error("write answer late");
	a_write_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	// main scenarios reached
	cover property (msi_req.valid && msi_req.vector == 5'h03);
	cover property (!irq_wire_n);
	cover property (s_axi_bvalid && s_axi_bready);
endmodule : irq_port_checker

bind tiered_msi_interrupt_logic irq_port_checker u_chk (.ref_clk, .rst, .irq_wire_n, .msi_req,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);

// File: msi_sink_model.sv
// host message sink: counts message requests and acknowledges them
// assumes requests are one-cycle pulses on ref_clk
`timescale 1ns/1ps
module msi_sink_model
	import tiered_irq_pkg::*;
(
	input  wire logic     ref_clk,
	input  wire logic     rst,
	input  wire msi_req_s msi_req,
	input  wire logic     slow,
	output logic          msi_ack,
	output int            msg_count,
	output logic [4:0]    last_vector
);
	logic [3:0] ack_pipe_q;
	// each pulse is one message: count it, keep its number
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			msg_count <= 0;
			last_vector <= 5'h1F;
			ack_pipe_q <= 4'h0;
		end else begin
			ack_pipe_q <= {ack_pipe_q[2:0], msi_req.valid};
			if (msi_req.valid) begin
				msg_count <= msg_count + 1;
				last_vector <= msi_req.vector;
			end
		end
	end
	// slow answers arrive late, possibly while the block wants to send again
	assign msi_ack = slow ? ack_pipe_q[3] : ack_pipe_q[0];
endmodule : msi_sink_model

// File: tiered_msi_interrupt_logic_tb.sv
// self-checking bench for the tiered interrupt block over axi4-lite
// assumes six ports, share-last on short grants, the host sink model
`timescale 1ns/1ps
`include "tiered_irq_params.svh"
module tiered_msi_interrupt_logic_tb
	import tiered_irq_pkg::*;
;
	typedef struct {
		logic [11:0] a;
		logic [31:0] d;
		int          ev;
		logic [31:0] s;
		logic        w;
		int          m;
		logic [4:0]  v;
	} row_s;
	logic         ref_clk = 1'b0, rst = 1'b1, slow = 1'b0;
	logic         awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
	logic [11:0]  awa = 12'h000, ara = 12'h000;
	logic [31:0]  wd = 32'h0, rdata, rd, rdata_fb;
	logic [191:0] port_events = '0;
	logic         irq_wire_n, msi_ack, awr, wr, bvld, arr, rvld;
	logic [1:0]   bresp, rresp, rsp;
	logic [4:0]   last_vector;
	msi_req_s     msi_req;
	int           msg_count, miscompares = 0, tests_run = 0;
	logic [11:0]  ha [4] = '{12'h008, 12'h004, 12'h00C, 12'h040};
	logic [31:0]  he [4] = '{32'h27, 32'h0, 32'h3F, 32'h0};
	// write addr, data (FFF none), event port (-1 none), summary, wire, messages, vector
	row_s rows [22] = '{
		'{12'h180, 32'h1, -1, 32'h0, 1'b1, 0, 5'h1F},
		'{12'hFFF, 32'h0, 0, 32'h1, 1'b1, 0, 5'h1F},
		'{12'h004, 32'h1, -1, 32'h1, 1'b0, 0, 5'h1F},
		'{12'h000, 32'h1, -1, 32'h1, 1'b0, 0, 5'h1F},
		'{12'h100, 32'hFFFFFFFF, -1, 32'h1, 1'b0, 0, 5'h1F},
		'{12'h000, 32'h1, -1, 32'h0, 1'b1, 0, 5'h1F},
		'{12'hFFF, 32'h0, 1, 32'h0, 1'b1, 0, 5'h1F},
		'{12'h008, 32'h1, -1, 32'h0, 1'b1, 0, 5'h1F},
		'{12'hFFF, 32'h0, 0, 32'h1, 1'b1, 1, 5'h00},
		'{12'h184, 32'h1, -1, 32'h3, 1'b1, 2, 5'h00},
		'{12'h100, 32'hFFFFFFFF, -1, 32'h3, 1'b1, 2, 5'h1F},
		'{12'h000, 32'h1, -1, 32'h2, 1'b1, 3, 5'h00},
		'{12'h104, 32'hFFFFFFFF, -1, 32'h2, 1'b1, 3, 5'h1F},
		'{12'h000, 32'h2, -1, 32'h0, 1'b1, 3, 5'h1F},
		'{12'h008, 32'h21, -1, 32'h0, 1'b1, 3, 5'h1F},
		'{12'h194, 32'h1, -1, 32'h0, 1'b1, 3, 5'h1F},
		'{12'hFFF, 32'h0, 5, 32'h20, 1'b1, 4, 5'h03},
		'{12'hFFF, 32'h0, 1, 32'h22, 1'b1, 5, 5'h01},
		'{12'hFFF, 32'h0, 2, 32'h22, 1'b1, 5, 5'h1F},
		'{12'h188, 32'h1, -1, 32'h26, 1'b1, 6, 5'h02},
		'{12'h004, 32'h0, -1, 32'h26, 1'b1, 6, 5'h1F},
		'{12'hFFF, 32'h0, 0, 32'h27, 1'b1, 6, 5'h1F}};

	tiered_msi_interrupt_logic #(.NPORTS(6), .FALLBACK(1'b0)) u_dut (.ref_clk, .rst,
		.port_events, .irq_wire_n, .msi_req, .msi_ack, .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bvld),
		.s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvld), .s_axi_rready(rrdy));
	msi_sink_model u_host (.ref_clk, .rst, .msi_req, .slow, .msi_ack, .msg_count, .last_vector);
	// same bus traffic into a build that falls back on a short grant
	tiered_msi_interrupt_logic #(.NPORTS(6), .FALLBACK(1'b1)) u_dut_fb (.ref_clk, .rst,
		.port_events, .irq_wire_n(), .msi_req(), .msi_ack, .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wv), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
		.s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(),
		.s_axi_rdata(rdata_fb), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rrdy));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// handshakes are judged at the falling edge, acted on at the next rising edge
	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
		logic ta, tw, b;
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		brdy <= 1'b1;
		b = 1'b0;
		while (!b) begin
			@(negedge ref_clk);
			ta = awv && awr;
			tw = wv && wr;
			b = bvld;
			@(posedge ref_clk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
			if (b) brdy <= 1'b0;
		end
	endtask : wr_reg

	task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
		logic t, b;
		ara <= a;
		arv <= 1'b1;
		rrdy <= 1'b1;
		b = 1'b0;
		while (!b) begin
			@(negedge ref_clk);
			t = arv && arr;
			b = rvld;
			d = rdata;
			rsp = rresp;
			@(posedge ref_clk);
			if (t) arv <= 1'b0;
			if (b) rrdy <= 1'b0;
		end
	endtask : rd_reg

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : complete_run

	initial begin
		forever #2 ref_clk = ~ref_clk;
	end

	// a hang ends the run as a mismatch
	initial begin
		repeat (4000) @(posedge ref_clk);
		miscompares++;
		complete_run();
	end

	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		// ordinary cases: program, raise an event, then look at summary, wire and host
		foreach (rows[i]) begin
			slow <= (i > 13);
			if (rows[i].a != 12'hFFF) wr_reg(rows[i].a, rows[i].d);
			if (rows[i].ev >= 0) port_events[rows[i].ev*32] <= 1'b1;
			@(posedge ref_clk);
			port_events <= '0;
			repeat (16) @(posedge ref_clk);
			rd_reg(12'h000, rd);
			check(rd, rows[i].s);
			check(32'(irq_wire_n), 32'(rows[i].w));
			check(32'(msg_count), 32'(rows[i].m));
			if (rows[i].v != 5'h1F) check(32'(last_vector), 32'(rows[i].v));
			$display("row %0d done", i);
		end
		// register map, unmapped place last
		foreach (ha[i]) begin
			@(posedge ref_clk);
			rd_reg(ha[i], rd);
			check(rd, he[i]);
		end
		check(32'(rsp), 32'(`RESP_SLVERR));
		// fallback build reports the revert on its control word
		rd_reg(12'h004, rd);
		check(rdata_fb, 32'h2);
		check(rd, 32'h0);
		// unmapped write answers with an error
		wr_reg(12'h040, 32'h0);
		check(32'(bresp), 32'(`RESP_SLVERR));
		$display("register map done");
		// reset in mid-run with summary and status set
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		rd_reg(12'h000, rd);
		check(rd, 32'h0);
		check(32'(irq_wire_n), 32'h1);
		check(32'(msg_count), 32'h0);
		$display("reset test done");
		complete_run();
	end
endmodule : tiered_msi_interrupt_logic_tb
